//--- aam_device.sv
// What this block does
// - Each fault gets exactly one of three levels
// - Severe levels: lamp, output, decelerate, then servo off
// - Alarm reset clears operation-release alarms
// - Cold start cleared only by software reset
// - After cold recovery, re-home unless simple absolute
// - Output 15 on message alarm if enabled, in I/O patterns 0, 2, 3 and 4 only
// - 02C: data type change while monitoring
// - 02D: monitoring command with monitoring disabled
// - 02E: calendar command with calendar disabled
// - 048: overload risk raises message alarm
// - 04E: movement count exceeds threshold
// - 04F: travelled distance exceeds threshold
// - 080: move command while servo off
// - Host moves only after servo-on or complete
// - Simple modes: release stop, servo on first
// - Host stops monitoring before type change
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module aam_device #(
  parameter int CW = 32,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Link to host
  aam_if.device                   link,
  // Configuration parameters
  input  wire aam_pkg::aam_mode_e op_mode,
  input  wire logic [2:0]         io_pattern,
  input  wire logic               light_fault_par,
  input  wire logic [1:0]         mon_mode_par,
  input  wire logic               cal_en_par,
  input  wire logic               simple_abs,
  input  wire logic [CW-1:0]      thr_moves_pos2,
  input  wire logic [CW-1:0]      thr_moves_sc2,
  input  wire logic [CW-1:0]      thr_dist_pos2,
  input  wire logic [CW-1:0]      thr_dist_sc2,
  // Drive feedback
  input  wire logic               overload_risk,
  input  wire logic               move_done,
  input  wire logic [DW-1:0]      move_dist,
  input  wire logic               stopped,
  input  wire logic               cold_fault,
  input  wire logic [11:0]        cold_code,
  // Drive control
  output logic                    fault_lamp,
  output logic                    decel_req,
  output logic                    move_start,
  output logic                    home_required
);

  // ==========================================================
  // Event detection
  logic       servo_ff;
  logic       homed_ff;
  logic       mon_ff;
  logic       ovl_ff;
  logic       msg_ff;
  logic       rel_ff;
  logic       cold_ff;
  logic [11:0] code_ff;
  logic       pos_like;
  logic       sc2;
  logic       ev_mon_type;
  logic       ev_mon_off;
  logic       ev_cal_off;
  logic       ev_ovl;
  logic       ev_moves;
  logic       ev_dist;
  logic       ev_servo;
  logic       new_msg;
  logic       new_rel;
  logic       new_cold;
  logic       severe;
  logic       usage_on;
  logic [CW-1:0] thr_moves;
  logic [CW-1:0] thr_dist;
  logic [11:0] nxt_code;
  logic [11:0] msg_code;

  assign pos_like = (op_mode == aam_pkg::MODE_POS1) ||
                    (op_mode == aam_pkg::MODE_POS2) ||
                    (op_mode == aam_pkg::MODE_PULSE);
  assign sc2      = (op_mode == aam_pkg::MODE_SC2);
  assign severe   = rel_ff || cold_ff;

  assign ev_mon_type = pos_like && link.mon_type_chg && mon_ff;
  assign ev_mon_off  = pos_like && link.mon_start &&
                       (mon_mode_par == aam_pkg::MON_MODE_OFF);
  assign ev_cal_off  = (op_mode == aam_pkg::MODE_POS2) && link.cal_cmd &&
                       (cal_en_par != aam_pkg::CAL_EN_ON);
  assign ev_ovl      = overload_risk && !ovl_ff;
  assign ev_servo    = link.move_cmd && !servo_ff;

  // Usage counters only run in the two modes that carry thresholds
  assign usage_on  = (op_mode == aam_pkg::MODE_POS2) || sc2;
  assign thr_moves = sc2 ? thr_moves_sc2 : thr_moves_pos2;
  assign thr_dist  = sc2 ? thr_dist_sc2 : thr_dist_pos2;

  aam_usage_count #(.W(CW)) u_moves (
    .pclk           (pclk),
    .presetn        (presetn),
    .enable         (usage_on),
    .step_valid     (move_done),
    .step           (CW'(1)),
    .threshold      (thr_moves),
    .exceeded_pulse (ev_moves)
  );

  aam_usage_count #(.W(CW)) u_dist (
    .pclk           (pclk),
    .presetn        (presetn),
    .enable         (usage_on),
    .step_valid     (move_done),
    .step           (CW'(move_dist)),
    .threshold      (thr_dist),
    .exceeded_pulse (ev_dist)
  );

  // ==========================================================
  // Level classification: every source maps to one level
  assign new_msg  = ev_mon_type || ev_mon_off || ev_cal_off ||
                    ev_ovl || ev_moves || ev_dist;
  assign new_rel  = ev_servo;
  assign new_cold = cold_fault;

  always_comb
  begin
    if (ev_mon_type)
      msg_code = aam_pkg::CODE_MON_TYPE;
    else if (ev_mon_off)
      msg_code = aam_pkg::CODE_MON_OFF;
    else if (ev_cal_off)
      msg_code = aam_pkg::CODE_CAL_OFF;
    else if (ev_ovl)
      msg_code = aam_pkg::CODE_OVERLOAD;
    else if (ev_moves)
      msg_code = aam_pkg::CODE_MOVES;
    else
      msg_code = aam_pkg::CODE_DISTANCE;
  end

  // Latest event wins; among simultaneous ones the most severe
  always_comb
  begin
    nxt_code = code_ff;
    if (link.soft_reset)
      nxt_code = aam_pkg::CODE_NONE;
    else if (link.alarm_reset && !cold_ff)
      nxt_code = aam_pkg::CODE_NONE;
    if (new_cold)
      nxt_code = cold_code;
    else if (new_rel)
      nxt_code = aam_pkg::CODE_SERVO_OFF;
    else if (new_msg)
      nxt_code = msg_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      code_ff <= aam_pkg::CODE_NONE;
    else
      code_ff <= nxt_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovl_ff <= 1'b0;
    else
      ovl_ff <= overload_risk;
  end

  // ==========================================================
  // Pending levels; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msg_ff <= 1'b0;
    else if (new_msg)
      msg_ff <= 1'b1;
    else if (link.alarm_reset || link.soft_reset)
      msg_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rel_ff <= 1'b0;
    else if (new_rel)
      rel_ff <= 1'b1;
    else if (link.alarm_reset || link.soft_reset)
      rel_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cold_ff <= 1'b0;
    else if (new_cold)
      cold_ff <= 1'b1;
    else if (link.soft_reset)
      cold_ff <= 1'b0;
  end

  // ==========================================================
  // Servo, homing and monitoring state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      servo_ff <= 1'b0;
    else if (severe && stopped)
      servo_ff <= 1'b0;
    else if (link.servo_off_req)
      servo_ff <= 1'b0;
    else if (link.servo_on_req && !severe)
      servo_ff <= 1'b1;
  end

  // Cold recovery loses position unless the encoder keeps it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      homed_ff <= 1'b0;
    else if (cold_ff && link.soft_reset && !simple_abs)
      homed_ff <= 1'b0;
    else if (link.home_req && servo_ff && !severe)
      homed_ff <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_ff <= 1'b0;
    else if (link.mon_stop)
      mon_ff <= 1'b0;
    else if (link.mon_start && (mon_mode_par != aam_pkg::MON_MODE_OFF))
      mon_ff <= 1'b1;
  end

  // ==========================================================
  // Outputs; message alarms never stop motion
  assign fault_lamp     = severe;
  assign decel_req      = severe && servo_ff;
  assign move_start     = link.move_cmd && servo_ff && homed_ff &&
                          !severe;
  assign home_required  = !homed_ff;

  assign link.fault_out_n       = !severe;
  assign link.out15             = msg_ff && (light_fault_par ==
                                  aam_pkg::LIGHT_FAULT_ON) &&
                                  (io_pattern != 3'h1) &&
                                  (io_pattern <= 3'h4);
  assign link.servo_on_status   = servo_ff;
  assign link.position_complete = servo_ff && stopped && !severe;
  assign link.home_done         = homed_ff;
  assign link.mon_active        = mon_ff;
  assign link.alarm_code        = code_ff;

endmodule

//--- aam_host.sv
`timescale 1ns/1ps
module aam_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Link to device
  aam_if.host              link
);

  // ==========================================================
  // APB decode
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic [31:0] prdata_ff;
  logic [31:0] status_word;
  logic [aam_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [aam_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [aam_pkg::IRQ_W-1:0] irq_ev;
  logic [9:0]  cmd_ff;
  logic        type_wait_ff;
  logic        fault_ff;
  logic        out15_ff;
  logic        refused;

  assign mapped   = (paddr == aam_pkg::OFF_CTRL) ||
                    (paddr == aam_pkg::OFF_STATUS) ||
                    (paddr == aam_pkg::OFF_IRQ_STAT) ||
                    (paddr == aam_pkg::OFF_IRQ_MASK);
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_ff;

  always_comb
  begin
    status_word = '0;
    status_word[aam_pkg::ST_SERVO]  = link.servo_on_status;
    status_word[aam_pkg::ST_PCOMP]  = link.position_complete;
    status_word[aam_pkg::ST_FAULT]  = !link.fault_out_n;
    status_word[aam_pkg::ST_OUT15]  = link.out15;
    status_word[aam_pkg::ST_HOMED]  = link.home_done;
    status_word[aam_pkg::ST_MON]    = link.mon_active;
    status_word[aam_pkg::ST_CODE +: 12] = link.alarm_code;
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
      unique case (paddr)
        aam_pkg::OFF_STATUS:   prdata_ff <= status_word;
        aam_pkg::OFF_IRQ_STAT: prdata_ff <= 32'(irq_stat_ff);
        aam_pkg::OFF_IRQ_MASK: prdata_ff <= 32'(irq_mask_ff);
        default:               prdata_ff <= '0;
      endcase
  end

  // ==========================================================
  // Commands: one-cycle pulses from CTRL writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_ff <= '0;
    else if (wr_acc && (paddr == aam_pkg::OFF_CTRL))
      cmd_ff <= pwdata[9:0];
    else
      cmd_ff <= '0;
  end

  // Type change waits one cycle behind a forced monitoring stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      type_wait_ff <= 1'b0;
    else
      type_wait_ff <= cmd_ff[aam_pkg::CTRL_MON_TYPE] && link.mon_active;
  end

  // Moves are dropped and flagged as refused unless the device reports it can take them
  assign refused = cmd_ff[aam_pkg::CTRL_MOVE] &&
                   !(link.servo_on_status || link.position_complete);

  assign link.move_cmd      = cmd_ff[aam_pkg::CTRL_MOVE] && !refused;
  assign link.servo_on_req  = cmd_ff[aam_pkg::CTRL_SERVO_ON];
  assign link.servo_off_req = cmd_ff[aam_pkg::CTRL_SERVO_OFF];
  assign link.alarm_reset   = cmd_ff[aam_pkg::CTRL_ALM_RESET];
  assign link.soft_reset    = cmd_ff[aam_pkg::CTRL_SOFT_RST];
  assign link.mon_start     = cmd_ff[aam_pkg::CTRL_MON_START];
  assign link.mon_stop      = cmd_ff[aam_pkg::CTRL_MON_STOP] ||
                              (cmd_ff[aam_pkg::CTRL_MON_TYPE] &&
                               link.mon_active);
  assign link.mon_type_chg  = type_wait_ff ||
                              (cmd_ff[aam_pkg::CTRL_MON_TYPE] &&
                               !link.mon_active);
  assign link.cal_cmd       = cmd_ff[aam_pkg::CTRL_CAL_CMD];
  assign link.home_req      = cmd_ff[aam_pkg::CTRL_HOME];

  // ==========================================================
  // Interrupts: sticky, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_ff <= 1'b0;
      out15_ff <= 1'b0;
    end
    else
    begin
      fault_ff <= !link.fault_out_n;
      out15_ff <= link.out15;
    end
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[aam_pkg::IRQ_FAULT]   = !link.fault_out_n && !fault_ff;
    irq_ev[aam_pkg::IRQ_MESSAGE] = link.out15 && !out15_ff;
    irq_ev[aam_pkg::IRQ_REFUSED] = refused;
    irq_ev[aam_pkg::IRQ_CLEARED] = link.fault_out_n && fault_ff;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_ff <= '0;
    else if (wr_acc && (paddr == aam_pkg::OFF_IRQ_STAT))
      irq_stat_ff <= (irq_stat_ff & ~pwdata[aam_pkg::IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_ff <= irq_stat_ff | irq_ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_ff <= aam_pkg::IRQ_MASK_RST;
    else if (wr_acc && (paddr == aam_pkg::OFF_IRQ_MASK))
      irq_mask_ff <= pwdata[aam_pkg::IRQ_W-1:0];
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

//--- aam_if.sv
`timescale 1ns/1ps
interface aam_if;
  // Host commands, one-cycle pulses
  logic        move_cmd;
  logic        servo_on_req;
  logic        servo_off_req;
  logic        alarm_reset;
  logic        soft_reset;
  logic        mon_start;
  logic        mon_stop;
  logic        mon_type_chg;
  logic        cal_cmd;
  logic        home_req;
  // Device status, levels
  logic        servo_on_status;
  logic        position_complete;
  logic        fault_out_n;
  logic        out15;
  logic        home_done;
  logic        mon_active;
  logic [11:0] alarm_code;

  modport device (
    input  move_cmd, servo_on_req, servo_off_req, alarm_reset, soft_reset,
    input  mon_start, mon_stop, mon_type_chg, cal_cmd, home_req,
    output servo_on_status, position_complete, fault_out_n, out15,
    output home_done, mon_active, alarm_code
  );

  modport host (
    output move_cmd, servo_on_req, servo_off_req, alarm_reset, soft_reset,
    output mon_start, mon_stop, mon_type_chg, cal_cmd, home_req,
    input  servo_on_status, position_complete, fault_out_n, out15,
    input  home_done, mon_active, alarm_code
  );
endinterface

//--- aam_pkg.sv
package aam_pkg;

  // ==========================================================
  // Alarm codes (three hex digits)
  localparam logic [11:0] CODE_NONE      = 12'h000;
  localparam logic [11:0] CODE_MON_TYPE  = 12'h02c;
  localparam logic [11:0] CODE_MON_OFF   = 12'h02d;
  localparam logic [11:0] CODE_CAL_OFF   = 12'h02e;
  localparam logic [11:0] CODE_OVERLOAD  = 12'h048;
  localparam logic [11:0] CODE_MOVES     = 12'h04e;
  localparam logic [11:0] CODE_DISTANCE  = 12'h04f;
  localparam logic [11:0] CODE_SERVO_OFF = 12'h080;

  // ==========================================================
  // Operating modes and parameter values
  typedef enum logic [2:0] {
    MODE_POS1,
    MODE_POS2,
    MODE_PULSE,
    MODE_SC1,
    MODE_SC2
  } aam_mode_e;

  localparam logic [1:0] MON_MODE_OFF   = 2'h0;
  localparam logic       CAL_EN_ON      = 1'h1;
  localparam logic       LIGHT_FAULT_ON = 1'h1;

  // ==========================================================
  // Host register map (APB byte addresses)
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;

  // CTRL: write-one command bits
  localparam int CTRL_MOVE      = 0;
  localparam int CTRL_SERVO_ON  = 1;
  localparam int CTRL_SERVO_OFF = 2;
  localparam int CTRL_ALM_RESET = 3;
  localparam int CTRL_SOFT_RST  = 4;
  localparam int CTRL_MON_START = 5;
  localparam int CTRL_MON_STOP  = 6;
  localparam int CTRL_MON_TYPE  = 7;
  localparam int CTRL_CAL_CMD   = 8;
  localparam int CTRL_HOME      = 9;

  // STATUS fields
  localparam int ST_SERVO  = 0;
  localparam int ST_PCOMP  = 1;
  localparam int ST_FAULT  = 2;
  localparam int ST_OUT15  = 3;
  localparam int ST_HOMED  = 4;
  localparam int ST_MON    = 5;
  localparam int ST_CODE   = 16;

  // IRQ status / mask bits
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_MESSAGE = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_CLEARED = 3;
  localparam int IRQ_W       = 4;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

endpackage

//--- aam_props.sv
`timescale 1ns/1ps
module aam_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Host commands
  input wire logic        move_cmd,
  input wire logic        servo_on_req,
  input wire logic        alarm_reset,
  input wire logic        soft_reset,
  input wire logic        mon_start,
  input wire logic        mon_type_chg,
  input wire logic        cal_cmd,
  // Device status
  input wire logic        servo_on_status,
  input wire logic        position_complete,
  input wire logic        fault_out_n,
  input wire logic        out15,
  input wire logic        mon_active,
  input wire logic [11:0] alarm_code
);
  // ==========================================
  // Link properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_move_gate: assert property (
    move_cmd |-> servo_on_status || position_complete)
    else $error("move sent without servo on or complete");
  a_pcomp_quiet: assert property (
    position_complete |-> servo_on_status && fault_out_n)
    else $error("complete shown during severe alarm or servo off");
  a_fault_code: assert property (
    !fault_out_n |-> alarm_code != 12'h000)
    else $error("fault output without alarm code");
  // A new alarm in the same cycle wins over the reset
  a_reset_clears: assert property (
    alarm_reset && fault_out_n &&
    !(mon_start || mon_type_chg || cal_cmd || move_cmd)
    |=> alarm_code == 12'h000)
    else $error("alarm reset left a code");
  a_cold_holds: assert property (
    alarm_reset && !fault_out_n && alarm_code != 12'h080
    |=> !fault_out_n)
    else $error("ordinary reset cleared cold alarm");
  a_soft_clears: assert property (
    soft_reset && !move_cmd |=> fault_out_n)
    else $error("soft reset did not clear fault");
  a_servo_blocked: assert property (
    !fault_out_n && !servo_on_status && servo_on_req
    |=> !servo_on_status)
    else $error("servo turned on during severe alarm");
  a_type_order: assert property (
    mon_type_chg |-> !mon_active)
    else $error("type change while monitoring");
  c_fault: cover property ($fell(fault_out_n));
  c_light: cover property ($rose(out15));
  c_type: cover property (mon_type_chg);
endmodule

//--- aam_usage_count.sv
`timescale 1ns/1ps
module aam_usage_count #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Accumulation
  input  wire logic         enable,
  input  wire logic         step_valid,
  input  wire logic [W-1:0] step,
  input  wire logic [W-1:0] threshold,
  // Result
  output logic              exceeded_pulse
);

  logic [W:0] total_ff;
  logic       over_ff;
  logic [W:0] nxt_total;

  // Saturate rather than wrap so a long-lived unit never re-arms itself
  always_comb
  begin
    nxt_total = total_ff + {1'b0, step};
    if (nxt_total[W])
      nxt_total = {1'b0, {W{1'b1}}};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      total_ff <= '0;
    else if (enable && step_valid)
      total_ff <= nxt_total;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      over_ff <= 1'b0;
    else
      over_ff <= enable && (total_ff[W-1:0] > threshold);
  end

  assign exceeded_pulse = enable && (total_ff[W-1:0] > threshold) && !over_ff;

endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // Stimulus and observed signals
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata, q;
  logic                pready, pslverr, irq, e;
  logic                light = 1'b1, cal_en = 1'b0, ovl = 1'b0;
  logic                mdone = 1'b0, stopped = 1'b1, cold = 1'b0;
  logic [1:0]          mon_par = 2'h0;
  logic [2:0]          iop = 3'h0;
  logic [31:0]         thr_m = 32'h2, thr_d = 32'hffff_ffff;
  logic [15:0]         mdist = 16'h0;
  logic [11:0]         cold_code = 12'h0a1;
  logic                lamp, decel, mstart, home_req_o;
  int                  errors = 0, n_compared = 0, starts = 0;
  int                  seed, tot_m = 0, tot_d = 0;
  logic [11:0]         code_m;
  logic [15:0]         dq[$];

  always #10 pclk = ~pclk;
  always @(posedge pclk)
    if (mstart === 1'b1)
      starts <= starts + 1;

  aam_if link_if ();
  aam_device aam_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if),
    .op_mode(aam_pkg::MODE_POS2), .io_pattern(iop), .light_fault_par(light),
    .mon_mode_par(mon_par), .cal_en_par(cal_en), .simple_abs(1'b0),
    .thr_moves_pos2(thr_m), .thr_moves_sc2(32'hffff_ffff),
    .thr_dist_pos2(thr_d), .thr_dist_sc2(32'hffff_ffff),
    .overload_risk(ovl), .move_done(mdone), .move_dist(mdist),
    .stopped(stopped), .cold_fault(cold), .cold_code(cold_code),
    .fault_lamp(lamp), .decel_req(decel), .move_start(mstart),
    .home_required(home_req_o));
  aam_host aam_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link_if));
  aam_props aam_props_inst (.pclk(pclk), .presetn(presetn),
    .move_cmd(link_if.move_cmd), .servo_on_req(link_if.servo_on_req),
    .alarm_reset(link_if.alarm_reset), .soft_reset(link_if.soft_reset),
    .mon_start(link_if.mon_start), .mon_type_chg(link_if.mon_type_chg),
    .cal_cmd(link_if.cal_cmd), .servo_on_status(link_if.servo_on_status),
    .position_complete(link_if.position_complete),
    .fault_out_n(link_if.fault_out_n), .out15(link_if.out15),
    .mon_active(link_if.mon_active), .alarm_code(link_if.alarm_code));

  // ==========================================
  // Checks and bus cycles
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Every transfer starts just after an edge; pready ends the access
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input int b);
    apb(aam_pkg::OFF_CTRL, 1'b1, 32'h1 << b);
    repeat (4) @(posedge pclk);
  endtask

  task automatic st(input logic [11:0] c, input logic f, input logic o);
    apb(aam_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_reg({20'h0, q[aam_pkg::ST_CODE +: 12]}, {20'h0, c});
    chk_pin(q[aam_pkg::ST_FAULT], f);
    chk_pin(q[aam_pkg::ST_OUT15], o);
  endtask

  task automatic pulse_in(input int k);
    @(posedge pclk);
    if (k == 0) mdone <= 1'b1;
    else cold <= 1'b1;
    @(posedge pclk);
    mdone <= 1'b0;
    cold <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic end_sim;
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100us;
    errors++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    seed = $urandom(32'ha36b);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h010, 1'b0, 32'h0);
    chk_pin(e, 1'b1);
    st(12'h000, 1'b0, 1'b0);
    // Host holds back a move while the servo is off
    cmd(aam_pkg::CTRL_MOVE);
    chk_reg(starts, 0);
    apb(aam_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    chk_reg(q, 32'h4);
    chk_pin(irq, 1'b0);
    apb(aam_pkg::OFF_IRQ_MASK, 1'b1, 32'h4);
    @(negedge pclk);
    chk_pin(irq, 1'b1);
    apb(aam_pkg::OFF_IRQ_STAT, 1'b1, 32'h4);
    @(negedge pclk);
    chk_pin(irq, 1'b0);
    // Monitoring with the function disabled, then enabled
    cmd(aam_pkg::CTRL_MON_START);
    st(12'h02d, 1'b0, 1'b1);
    chk_pin(lamp, 1'b0);
    cmd(aam_pkg::CTRL_ALM_RESET);
    st(12'h000, 1'b0, 1'b0);
    mon_par <= 2'h1 + 2'($urandom_range(0, 1));
    cmd(aam_pkg::CTRL_MON_START);
    chk_pin(link_if.mon_active, 1'b1);
    cmd(aam_pkg::CTRL_MON_TYPE);
    chk_pin(link_if.mon_active, 1'b0);
    st(12'h000, 1'b0, 1'b0);
    // Calendar disabled, light output off, then calendar enabled
    light <= 1'b0;
    cmd(aam_pkg::CTRL_CAL_CMD);
    st(12'h02e, 1'b0, 1'b0);
    cmd(aam_pkg::CTRL_ALM_RESET);
    cal_en <= 1'b1;
    light <= 1'b1;
    cmd(aam_pkg::CTRL_CAL_CMD);
    st(12'h000, 1'b0, 1'b0);
    @(posedge pclk);
    ovl <= 1'b1;
    repeat (3) @(posedge pclk);
    st(12'h048, 1'b0, 1'b1);
    ovl <= 1'b0;
    iop <= 3'h1;
    st(12'h048, 1'b0, 1'b0);
    iop <= 3'h0;
    cmd(aam_pkg::CTRL_ALM_RESET);
    // Usage counters: distance trips on move two, count on move three
    cmd(aam_pkg::CTRL_SERVO_ON);
    cmd(aam_pkg::CTRL_HOME);
    chk_pin(home_req_o, 1'b0);
    chk_pin(link_if.home_done, 1'b1);
    cmd(aam_pkg::CTRL_MOVE);
    chk_reg(starts, 1);
    for (int i = 0; i < 3; i++)
      dq.push_back(16'h1 + 16'($urandom_range(0, 255)));
    thr_d <= {16'h0, dq[0]};
    code_m = 12'h000;
    for (int i = 0; i < 3; i++)
    begin
      mdist <= dq[i];
      pulse_in(0);
      tot_m++;
      tot_d += dq[i];
      if (tot_m == 3) code_m = 12'h04e;
      else if (tot_d > dq[0]) code_m = 12'h04f;
      st(code_m, 1'b0, code_m != 12'h000);
    end
    // Cold start: stop, servo off, survives ordinary reset
    stopped <= 1'b0;
    pulse_in(1);
    @(negedge pclk);
    chk_pin(link_if.fault_out_n, 1'b0);
    chk_pin(lamp, 1'b1);
    chk_pin(decel, 1'b1);
    chk_pin(link_if.position_complete, 1'b0);
    @(posedge pclk);
    stopped <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk_pin(link_if.servo_on_status, 1'b0);
    cmd(aam_pkg::CTRL_SERVO_ON);
    chk_pin(link_if.servo_on_status, 1'b0);
    cmd(aam_pkg::CTRL_ALM_RESET);
    st(cold_code, 1'b1, 1'b0);
    cmd(aam_pkg::CTRL_SOFT_RST);
    st(12'h000, 1'b0, 1'b0);
    chk_pin(home_req_o, 1'b1);
    chk_pin(link_if.home_done, 1'b0);
    // Fault rise, message rise and fault cleared were all latched
    apb(aam_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    chk_reg(q, 32'hb);
    end_sim();
  end
endmodule
